// ### dio_router.sv
// Terminal input/output router between machine terminals and the
// parameter table, with an APB slave for routing setup and table access.
// Assumes terminal pins and the analog word are asynchronous to SYS_CLK.
//
// What this block does
// - Zero word reads as logic 0, else 1
// - Input writes true or false word
// - Input target may be any read/write table index
// - Words double as indices redirecting the link
// - Logic 0 is 0x0000, logic 1 is 0x0001
// - Defaults route inputs to 90, 118, 119
// - Third input closed: analog two drives current
// - Input targets must be read/write indices
// - Output source is any index below 550
// - Modulus strips sign before comparison
// - Output high only when value exceeds threshold
// - Inverted setting flips comparison result
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`include "dio_router_cfg.svh"
`default_nettype none

module dio_router
  import dio_router_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        SRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  input  wire logic [2:0]  DIN,
  input  wire logic [15:0] ANALOG2,
  output var  logic [2:0]  DOUT,
  output var  logic [15:0] CURRENT_CMD,
  output var  logic        RAMP_BYPASS
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Any non-zero word counts as true
  function automatic logic is_logic1(input word_t w);
    return (w != `LOGIC0_WORD);
  endfunction

  function automatic logic word_tag_ok(input word_t w);
    return (w < `TAG_LIMIT);
  endfunction

  function automatic logic word_tag_rw(input word_t w);
    return (w < `TAG_LIMIT) && (w < `RO_FIRST_TAG);
  endfunction

  // Sign-extend, optionally strip the sign; 17 bits so -32768 survives
  function automatic logic signed [16:0] proc_val(input word_t w, input logic strip);
    logic signed [16:0] s;
    s = signed'({w[15], w});
    if (strip && w[15]) begin
      s = -s;
    end
    return s;
  endfunction

  function automatic state_t reset_state();
    state_t s;
    s = '0;
    // Factory routes switch logic parameters on and off
    s.in_cfg[0].target    = `IN0_TARGET_RST;
    s.in_cfg[1].target    = `IN1_TARGET_RST;
    s.in_cfg[2].target    = `IN2_TARGET_RST;
    for (int i = 0; i < 3; i++) begin
      s.in_cfg[i].when_true  = `LOGIC1_WORD;
      s.in_cfg[i].when_false = `LOGIC0_WORD;
    end
    return s;
  endfunction

  // ----------------------------------------------------------------------
  // State and parameter table
  // ----------------------------------------------------------------------
  state_t st_reg;
  state_t st_next;
  word_t  tbl [0:549];

  // Bus decode results
  logic        is_tbl;
  logic        in_sel;
  logic        out_sel;
  logic [1:0]  in_i;
  logic [1:0]  out_i;
  logic [1:0]  field;
  tag_t        tbl_idx;
  logic [31:0] dec_rdata;
  logic        dec_err;
  word_t       wword;
  logic        commit;

  // Table write requests
  logic        tbl_we;
  word_t       route_val [0:2];
  word_t       link_src;
  word_t       link_dst;
  logic        link_ok;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Inputs at 0x010/0x020/0x030, outputs at 0x040/0x050/0x060, table at 0x1000
  always_comb begin
    wword     = PWDATA[15:0];
    is_tbl    = (PADDR[31:12] == 20'h00001);
    tbl_idx   = PADDR[11:2];
    in_sel    = (PADDR[31:6] == 26'h0) && (PADDR[5:4] != 2'b00);
    in_i      = PADDR[5:4] - 2'b01;
    out_sel   = (PADDR[31:8] == 24'h0) && (PADDR[7:6] == 2'b01) && (PADDR[5:4] != 2'b11);
    out_i     = PADDR[5:4];
    field     = PADDR[3:2];
    dec_rdata = 32'h0;
    dec_err   = 1'b0;
    if (is_tbl) begin
      dec_err = !word_tag_ok({6'h0, tbl_idx}) || (PWRITE && !word_tag_rw({6'h0, tbl_idx}));
      if (!dec_err) begin
        dec_rdata = {16'h0, tbl[tbl_idx]};
      end
    end else if (PADDR[31:0] == {20'h0, `ADDR_UNLOCK}) begin
      dec_rdata = {31'h0, st_reg.config_unlock};
    end else if (PADDR[31:0] == {20'h0, `ADDR_STATUS}) begin
      dec_err = PWRITE;
      dec_rdata[`STAT_DIN_LSB +: 3]  = st_reg.din_sync;
      dec_rdata[`STAT_DOUT_LSB +: 3] = st_reg.dout;
      dec_rdata[`STAT_BYPASS_BIT]    = st_reg.ramp_bypass;
    end else if (in_sel && field != 2'b11) begin
      // Routing words change only while unlocked
      dec_err = PWRITE && !st_reg.config_unlock;
      unique case (field)
        2'b00: begin
          dec_rdata = {22'h0, st_reg.in_cfg[in_i].target};
          // Any read/write index is a legal target
          if (PWRITE && !word_tag_rw(wword)) begin
            dec_err = 1'b1;
          end
        end
        2'b01: dec_rdata = {16'h0, st_reg.in_cfg[in_i].when_true};
        2'b10: dec_rdata = {16'h0, st_reg.in_cfg[in_i].when_false};
        default: dec_rdata = 32'h0;
      endcase
    end else if (out_sel) begin
      dec_err = PWRITE && !st_reg.config_unlock;
      unique case (field)
        2'b00: begin
          dec_rdata = {22'h0, st_reg.out_cfg[out_i].source};
          if (PWRITE && !word_tag_ok(wword)) begin
            dec_err = 1'b1;
          end
        end
        2'b01: begin
          dec_rdata = {16'h0, st_reg.out_cfg[out_i].threshold};
          if (PWRITE && (proc_val(wword, 1'b0) > `THR_MAX ||
                         proc_val(wword, 1'b0) < `THR_MIN)) begin
            dec_err = 1'b1;
          end
        end
        2'b10: dec_rdata = {16'h0, st_reg.out_cfg[out_i].modulus};
        2'b11: dec_rdata = {16'h0, st_reg.out_cfg[out_i].inverted};
      endcase
    end else begin
      dec_err = 1'b1;
    end
  end

  // Write lands at the edge where the master samples PREADY high
  assign commit = PSEL && PENABLE && st_reg.apb.pready && PWRITE && !st_reg.apb.pslverr;
  assign tbl_we = commit && is_tbl;

  // ----------------------------------------------------------------------
  // Routing values for the table
  // ----------------------------------------------------------------------
  // Link source and destination indices are themselves table words, so an
  // input aimed at the link source tag redirects the link
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      route_val[i] = st_reg.din_sync[i] ? st_reg.in_cfg[i].when_true
                                        : st_reg.in_cfg[i].when_false;
    end
    link_src = tbl[`LINK_SRC_TAG];
    link_dst = tbl[`LINK_DST_TAG];
    link_ok  = word_tag_ok(link_src) && word_tag_rw(link_dst);
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;

    // Two-stage synchronisers for terminal pins and analog word
    st_next.din_meta = DIN;
    st_next.din_sync = st_reg.din_meta;
    st_next.ana_meta = ANALOG2;
    st_next.ana_sync = st_reg.ana_meta;

    // Processing cycle divider
    st_next.tick = 1'b0;
    if (st_reg.tick_cnt == 8'(`PROC_CYCLES - 1)) begin
      st_next.tick_cnt = 8'h00;
      st_next.tick     = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 8'h01;
    end

    // All outputs refresh on the same tick as the table writes
    if (st_reg.tick) begin
      for (int o = 0; o < 3; o++) begin
        st_next.dout[o] =
          (proc_val(tbl[st_reg.out_cfg[o].source], is_logic1(st_reg.out_cfg[o].modulus))
           > proc_val(st_reg.out_cfg[o].threshold, 1'b0))
          ^ is_logic1(st_reg.out_cfg[o].inverted);
      end
      // Closed third input hands the current command to the analog word
      st_next.ramp_bypass = st_reg.din_sync[2];
      st_next.cur_cmd     = st_reg.din_sync[2] ? st_reg.ana_sync
                                               : tbl[`CUR_DMD_TAG];
    end

    // Access phase: one wait cycle, then registered answer
    st_next.apb.pready = 1'b0;
    if (PSEL && PENABLE && !st_reg.apb.pready) begin
      st_next.apb.pready  = 1'b1;
      st_next.apb.pslverr = dec_err;
      st_next.apb.prdata  = PWRITE ? 32'h0 : dec_rdata;
    end

    // Register commits
    if (commit && !is_tbl) begin
      if (PADDR[31:0] == {20'h0, `ADDR_UNLOCK}) begin
        st_next.config_unlock = PWDATA[0];
      end else if (in_sel) begin
        unique case (field)
          2'b00: st_next.in_cfg[in_i].target     = wword[9:0];
          2'b01: st_next.in_cfg[in_i].when_true  = wword;
          2'b10: st_next.in_cfg[in_i].when_false = wword;
          default: st_next.in_cfg[in_i].target   = st_reg.in_cfg[in_i].target;
        endcase
      end else if (out_sel) begin
        unique case (field)
          2'b00: st_next.out_cfg[out_i].source    = wword[9:0];
          2'b01: st_next.out_cfg[out_i].threshold = wword;
          2'b10: st_next.out_cfg[out_i].modulus   = wword;
          2'b11: st_next.out_cfg[out_i].inverted  = wword;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      st_reg <= reset_state();
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // Parameter table
  // ----------------------------------------------------------------------
  // Later writes win: input routes override the link, which overrides bus
  // writes landing on the same tick; a bus write there is lost
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      for (int k = 0; k < 550; k++) begin
        tbl[k] <= `LOGIC0_WORD;
      end
    end else begin
      if (tbl_we) begin
        tbl[tbl_idx] <= wword;
      end
      if (st_reg.tick) begin
        if (link_ok) begin
          tbl[link_dst[9:0]] <= tbl[link_src[9:0]];
        end
        for (int i = 0; i < 3; i++) begin
          tbl[st_reg.in_cfg[i].target] <= route_val[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign PRDATA      = st_reg.apb.prdata;
  assign PREADY      = st_reg.apb.pready;
  assign PSLVERR     = st_reg.apb.pslverr;
  assign DOUT        = st_reg.dout;
  assign CURRENT_CMD = st_reg.cur_cmd;
  assign RAMP_BYPASS = st_reg.ramp_bypass;

endmodule // dio_router

`default_nettype wire

// ### dio_router_cfg.svh
// Offsets, field positions, reset values and timing counts of the router.
// Assumes it is included by bare name in the design file.
`ifndef DIO_ROUTER_CFG_SVH
`define DIO_ROUTER_CFG_SVH

// ----------------------------------------------------------------------
// Parameter table
// ----------------------------------------------------------------------
`define TAG_LIMIT        16'd550
`define RO_FIRST_TAG     16'd500
`define LINK_SRC_TAG     10'd364
`define LINK_DST_TAG     10'd365
`define CUR_DMD_TAG      10'd120
`define LOGIC0_WORD      16'h0000
`define LOGIC1_WORD      16'h0001

// ----------------------------------------------------------------------
// Reset values and threshold limits
// ----------------------------------------------------------------------
`define IN0_TARGET_RST   10'd90
`define IN1_TARGET_RST   10'd118
`define IN2_TARGET_RST   10'd119
`define THR_MAX          17'sd30000
`define THR_MIN          -17'sd30000

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define ADDR_UNLOCK      12'h000
`define ADDR_STATUS      12'h004
`define STAT_DIN_LSB     0
`define STAT_DOUT_LSB    4
`define STAT_BYPASS_BIT  8

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SYS_CLK_NS       5
`define PROC_PERIOD_NS   1000
`define PROC_CYCLES      (`PROC_PERIOD_NS / `SYS_CLK_NS)

`endif

// ### dio_router_chk.sv
// Concurrent checks on the router's bus answers and output updates.
// Assumes it is bound to dio_router and sees only that module's ports.
`default_nettype none
module dio_router_chk (
  input wire logic        SYS_CLK,
  input wire logic        SRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [15:0] ANALOG2,
  input wire logic [2:0]  DOUT,
  input wire logic [15:0] CURRENT_CMD,
  input wire logic        RAMP_BYPASS
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  logic unlock_reg;
  // ----------------------------------------
  // Unlock shadow, kept from accepted writes
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (SRST) unlock_reg <= 1'b0;
    else if (PREADY && PWRITE && PADDR == 32'h0) unlock_reg <= PWDATA[0];
  end
  // ----------------------------------------
  // Access steps
  // ----------------------------------------
  sequence acc1_s;
    PSEL && PENABLE && !$past(PENABLE);
  endsequence
  sequence answer_s;
    !PREADY ##1 PREADY;
  endsequence
  sequence wr_done_s;
    PREADY && PWRITE;
  endsequence
  sequence out_change_s;
    $changed({DOUT, CURRENT_CMD, RAMP_BYPASS});
  endsequence
  ready_timing_a: assert property (acc1_s |-> answer_s) else $error("late answer");
  ready_pulse_a: assert property (PREADY |-> PSEL && PENABLE ##1 !PREADY)
    else $error("answer not one cycle");
  wr_rdata_a: assert property (wr_done_s |-> PRDATA == 32'h0) else $error("read data on write");
  locked_err_a: assert property (
    wr_done_s and (PADDR inside {[32'h10:32'h6c]} && !unlock_reg) |-> PSLVERR)
    else $error("locked write taken");
  target_ro_a: assert property (
    wr_done_s and (PADDR inside {32'h10, 32'h20, 32'h30} && PWDATA[15:0] >= 16'h1f4) |-> PSLVERR)
    else $error("read-only target taken");
  source_range_a: assert property (
    wr_done_s and (PADDR inside {32'h40, 32'h50, 32'h60} && PWDATA[15:0] >= 16'h226) |-> PSLVERR)
    else $error("source out of range taken");
  thr_range_a: assert property (
    wr_done_s and (PADDR inside {32'h44, 32'h54, 32'h64}
    && ($signed(PWDATA[15:0]) < -30000 || $signed(PWDATA[15:0]) > 30000)) |-> PSLVERR)
    else $error("threshold out of range taken");
  bypass_cmd_a: assert property ($rose(RAMP_BYPASS) |-> CURRENT_CMD == $past(ANALOG2, 3))
    else $error("bypass without analog command");
  out_tick_a: assert property (out_change_s |=> $stable({DOUT, CURRENT_CMD})[*8])
    else $error("outputs moved off tick");
endmodule // dio_router_chk

bind dio_router dio_router_chk chk (.SYS_CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PWDATA, .PRDATA, .PREADY, .PSLVERR, .ANALOG2, .DOUT, .CURRENT_CMD, .RAMP_BYPASS);
`default_nettype wire

// ### dio_router_pkg.sv
// Types shared by the terminal router: words, routing records, state.
// Assumes dio_router_cfg.svh is on the include path.
`default_nettype none

package dio_router_pkg;

  typedef logic [9:0]  tag_t;
  typedef logic [15:0] word_t;

  // One terminal input channel route
  typedef struct packed {
    tag_t  target;
    word_t when_true;
    word_t when_false;
  } in_route_t;

  // One terminal output channel route
  typedef struct packed {
    tag_t  source;
    word_t threshold;
    word_t modulus;
    word_t inverted;
  } out_route_t;

  // Registered bus answer
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_resp_t;

  // Registered state of the router, apart from the parameter table
  typedef struct packed {
    logic                  config_unlock;
    in_route_t  [2:0]      in_cfg;
    out_route_t [2:0]      out_cfg;
    logic       [2:0]      din_meta;
    logic       [2:0]      din_sync;
    word_t                 ana_meta;
    word_t                 ana_sync;
    logic       [2:0]      dout;
    word_t                 cur_cmd;
    logic                  ramp_bypass;
    logic       [7:0]      tick_cnt;
    logic                  tick;
    apb_resp_t             apb;
  } state_t;

endpackage

`default_nettype wire

// ### dio_term_model.sv
// Machine terminal model: contacts and the second analog source.
// Assumes the bench commands it right after rising edges.
`default_nettype none
module dio_term_model (
  input  wire logic        clk,
  input  wire logic [2:0]  set_din,
  input  wire logic [15:0] set_ana,
  output var  logic [2:0]  din = 3'h0,
  output var  logic [15:0] ana = 16'h0
);
  // Contacts settle a cycle late; analog held steady between commands
  always @(posedge clk) begin
    din <= set_din;
    ana <= set_ana;
  end
endmodule // dio_term_model
`default_nettype wire

// ### tb.sv
// Self-checking bench for the terminal router, driven over APB.
// Assumes checker, terminal model and design are compiled before it.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  sd = 3'h0;
  logic [15:0] sa = 16'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  din;
  logic [15:0] ana;
  logic [2:0]  dout;
  logic [15:0] cmd;
  logic        byp;
  logic [31:0] seed = 32'h9101;
  logic [32:0] q[$];
  logic [31:0] t;
  logic [31:0] f;
  int          fail_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  // Output rows: value, threshold, modulus word, inverted word
  logic [15:0] row [6][4] = '{'{16'h64, 16'h64, 16'h0, 16'h0}, '{16'h65, 16'h64, 16'h0, 16'h0},
    '{16'hff6a, 16'h64, 16'h0, 16'h0}, '{16'hff6a, 16'h64, 16'h2, 16'h0},
    '{16'hff6a, 16'h64, 16'h2, 16'h100}, '{16'h8ad1, 16'h8ad0, 16'h0, 16'h0}};
  logic [5:0]  lvl = 6'h2a;
  logic [31:0] dflt [3] = '{32'h5a, 32'h76, 32'h77};

  dio_term_model term (.clk(clk), .set_din(sd), .set_ana(sa), .din(din), .ana(ana));
  dio_router dut (.SYS_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .DIN(din), .ANALOG2(ana), .DOUT(dout), .CURRENT_CMD(cmd), .RAMP_BYPASS(byp));

  always #2.5 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cmp(input string n, input logic [32:0] e, input logic [32:0] g);
    n_tests++;
    if (e !== g) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // One APB access; reads expect d, writes expect zero read data
  task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] d,
                     input logic e);
    q.push_back({e, w ? 32'h0 : d});
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= ad;
    pwdata <= w ? d : 32'h0;
    @(posedge clk);
    pen <= 1'b1;
    // Look at PREADY mid-cycle, where it is settled, then finish at the rising edge
    do @(negedge clk); while (pready !== 1'b1);
    @(posedge clk);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  // Three processing ticks cover input sync plus one tick of table lag
  task automatic ticks();
    repeat (600) @(posedge clk);
  endtask

  // ----------------------------------------
  // Answer monitor and hang guard
  // ----------------------------------------
  // Sampled on the falling edge so the registered answer has settled
  always @(negedge clk) begin
    cyc++;
    if (pready === 1'b1) begin
      if (q.size() == 0) cmp("apb_extra", 33'h0, 33'h1);
      else cmp("apb", q.pop_front(), {pslverr, prdata});
    end
    if (cyc == 12000) begin
      fail_count++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 3; i++) bus(0, 32'h10 + 32'h10 * i, dflt[i], 0);
    bus(0, 32'hc, 32'h0, 1);
    bus(1, 32'h10, 32'he, 1);
    bus(1, 32'h0, 32'h1, 0);
    bus(1, 32'h4, 32'h0, 1);
    bus(1, 32'h10, 32'h1f4, 1);
    bus(1, 32'h40, 32'h226, 1);
    bus(1, 32'h44, 32'h8acf, 1);
    t = rnd() & 32'hffff;
    f = rnd() & 32'hffff;
    sa <= rnd() >> 16;
    bus(1, 32'h10, 32'he, 0);
    bus(1, 32'h14, t, 0);
    bus(1, 32'h18, f, 0);
    sd <= 3'h5;
    ticks();
    bus(0, 32'h1038, t, 0);
    bus(0, 32'h11dc, 32'h1, 0);
    bus(0, 32'h4, 32'h105, 0);
    cmp("cmd", {17'h0, sa}, {17'h0, cmd});
    cmp("bypass", 33'h1, {32'h0, byp});
    sd <= 3'h0;
    ticks();
    bus(0, 32'h1038, f, 0);
    bus(0, 32'h11dc, 32'h0, 0);
    cmp("cmd", 33'h0, {17'h0, cmd});
    bus(1, 32'h20, 32'h16c, 0);
    bus(1, 32'h24, 32'h81, 0);
    bus(1, 32'h28, 32'h80, 0);
    bus(1, 32'h15b4, 32'h135, 0);
    bus(1, 32'h1204, t, 0);
    bus(1, 32'h1200, f, 0);
    sd <= 3'h2;
    ticks();
    bus(0, 32'h14d4, t, 0);
    sd <= 3'h0;
    ticks();
    bus(0, 32'h14d4, f, 0);
    bus(1, 32'h40, 32'hc8, 0);
    for (int i = 0; i < 6; i++) begin
      bus(1, 32'h44, {16'h0, row[i][1]}, 0);
      bus(1, 32'h48, {16'h0, row[i][2]}, 0);
      bus(1, 32'h4c, {16'h0, row[i][3]}, 0);
      bus(1, 32'h1320, {16'h0, row[i][0]}, 0);
      ticks();
      cmp("dout0", {32'h0, lvl[i]}, {32'h0, dout[0]});
    end
    bus(1, 32'h0, 32'h0, 0);
    bus(1, 32'h10, 32'h5a, 1);
    bus(0, 32'h1898, 32'h0, 1);
    bus(1, 32'h17d0, 32'h5, 1);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    bus(0, 32'h10, 32'h5a, 0);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
